// file: hdl/dac_write_consts.vh
// Constants for the parallel DAC write controller
`ifndef DAC_WRITE_CONSTS_VH
`define DAC_WRITE_CONSTS_VH
`define DAC_DATA_W 12
`define DAC_MSB_IDX 11
`define DAC_CODE_ZERO 12'h000
`define DAC_CODE_FULL 12'hFFF
`define DAC_CODE_MID 12'h800
`define DAC_CLK_NS 50
`define DAC_CS_MIN_NS 40
`define DAC_SETUP_NS 50
`define DAC_WAIT_CYCLES 1
`define DAC_ST_IDLE 2'h0
`define DAC_ST_SETUP 2'h1
`define DAC_ST_STROBE 2'h2
`define DAC_ST_RELEASE 2'h3
`endif

// file: hdl/dac_code_format.v
// Code conversion from user sample to converter input coding
`timescale 1ns/100ps
module dac_code_format #(
  parameter WIDTH = 12
) (
  input wire [WIDTH-1:0] sample,
  input wire twosComplement,
  output wire [WIDTH-1:0] code
);
  // Twos complement maps to offset binary by flipping only the MSB
  assign code = {sample[WIDTH-1] ^ twosComplement, sample[WIDTH-2:0]};
endmodule // dac_code_format

// file: hdl/dac_write_host.v
// Host-side controller driving the parallel write port of a 12-bit DAC
`timescale 1ns/100ps
`include "dac_write_consts.vh"
module dac_write_host #(
  parameter WIDTH = `DAC_DATA_W,
  parameter NPORTS = 8,
  parameter PORT_W = 3,
  parameter WAIT_STATES = `DAC_WAIT_CYCLES
) (
  input wire clk,
  input wire rst_n,
  input wire writeReq,
  input wire [WIDTH-1:0] writeSample,
  input wire [PORT_W-1:0] writePort,
  input wire twosComplement,
  output reg writeReady,
  output reg writeDone,
  output reg [WIDTH-1:0] dataInputs,
  output reg [NPORTS-1:0] chipSelect_n,
  output reg transferAcknowledge_n,
  output reg [WIDTH-1:0] lastCode
);
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  // Least times round up to whole clocks
  localparam integer SETUP_CYC = (`DAC_SETUP_NS + `DAC_CLK_NS - 1) / `DAC_CLK_NS;
  localparam integer CS_CYC_RAW = (`DAC_CS_MIN_NS + `DAC_CLK_NS - 1) / `DAC_CLK_NS;
  localparam integer CS_CYC = CS_CYC_RAW + WAIT_STATES;
  localparam integer SETUP_LAST_I = SETUP_CYC - 1;
  localparam integer CS_LAST_I = CS_CYC - 1;
  // Counters are four bits, so setup and select stretch top out at sixteen clocks
  // Whole-clock rounding costs up to one clock on each of setup and select per write but needs no faster clock
  localparam [3:0] SETUP_LAST = SETUP_LAST_I[3:0];
  localparam [3:0] CS_LAST = CS_LAST_I[3:0];

  wire [WIDTH-1:0] fmtCode;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [3:0] cnt_q;
  reg [3:0] cnt_d;
  reg [WIDTH-1:0] code_q;
  reg [PORT_W-1:0] port_q;
  wire [NPORTS-1:0] portDecode;

  dac_code_format #(.WIDTH(WIDTH)) u_fmt (
    .sample(writeSample),
    .twosComplement(twosComplement),
    .code(fmtCode)
  );

  // ----------------------------------------
  // Port decode, one strobe per device
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NPORTS; gi = gi + 1) begin : g_dec
      assign portDecode[gi] = (port_q == gi);
    end
  endgenerate

  // ----------------------------------------
  // State codes
  // ----------------------------------------
  localparam [1:0] ST_IDLE = `DAC_ST_IDLE;
  localparam [1:0] ST_SETUP = `DAC_ST_SETUP;
  localparam [1:0] ST_STROBE = `DAC_ST_STROBE;
  localparam [1:0] ST_RELEASE = `DAC_ST_RELEASE;

  // Requests are taken only from idle; busy-time requests are dropped unseen
  wire take = (state_q == ST_IDLE) && writeReq;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_IDLE: begin
        cnt_d = 4'h0;
        if (writeReq) begin
          state_d = ST_SETUP;
        end
      end
      ST_SETUP: begin
        // Data already on the bus here, so it leads the falling select
        if (cnt_q >= SETUP_LAST) begin
          state_d = ST_STROBE;
          cnt_d = 4'h0;
        end else begin
          cnt_d = cnt_q + 4'h1;
        end
      end
      ST_STROBE: begin
        // Select stretched by the wait states before release
        if (cnt_q >= CS_LAST) begin
          state_d = ST_RELEASE;
          cnt_d = 4'h0;
        end else begin
          cnt_d = cnt_q + 4'h1;
        end
      end
      ST_RELEASE: begin
        // Select already high; one spare clock keeps data steady past the edge
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
        cnt_d = 4'h0;
      end
    endcase
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always @(posedge clk) begin
    // Counter and state advance together; nothing else reads the counter
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------
  // Request capture
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      code_q <= `DAC_CODE_ZERO;
      port_q <= {PORT_W{1'b0}};
    end else if (take) begin
      // Kept for the delivered-code report after the select has risen
      code_q <= fmtCode;
      port_q <= writePort;
    end
  end

  // ----------------------------------------
  // User handshake
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      writeReady <= 1'b0;
      writeDone <= 1'b0;
    end else begin
      // Ready follows the next state, so it is high while idle, except in reset and until the first clock edge after reset
      writeReady <= (state_d == ST_IDLE);
      // One-clock pulse as the sequencer leaves release
      writeDone <= (state_q == ST_RELEASE);
    end
  end

  // ----------------------------------------
  // Data bus
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      dataInputs <= `DAC_CODE_ZERO;
    end else if (take) begin
      // Driven at the take, a clock ahead of the select, held to the next write
      dataInputs <= fmtCode;
    end
  end

  // ----------------------------------------
  // Chip select
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      chipSelect_n <= {NPORTS{1'b1}};
    end else if (state_d == ST_STROBE) begin
      // Only the decoded port pulls its select low
      chipSelect_n <= ~portDecode;
    end else begin
      chipSelect_n <= {NPORTS{1'b1}};
    end
  end

  // ----------------------------------------
  // Acknowledge
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      transferAcknowledge_n <= 1'b1;
    end else begin
      // Low for one clock from the same edge that puts the select back high, ending the host cycle
      transferAcknowledge_n <= ~(state_d == ST_RELEASE);
    end
  end

  // ----------------------------------------
  // Delivered code
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      lastCode <= `DAC_CODE_ZERO;
    end else if (state_q == ST_RELEASE) begin
      // Rising select edge has latched the word in the device by now
      lastCode <= code_q;
    end
  end
endmodule // dac_write_host

// file: testbench/dac_write_host_sva.sv
// Port assertions for the DAC write host
`timescale 1ns/100ps
module dac_write_host_sva #(parameter WIDTH = 12, NPORTS = 8) (input wire clk, rst_n, writeReq,
  twosComplement, writeReady, writeDone, transferAcknowledge_n, input wire [WIDTH-1:0] writeSample,
  dataInputs, lastCode, input wire [NPORTS-1:0] chipSelect_n);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire idle = &chipSelect_n;
  wire take = writeReq && writeReady;
  a_one_select: assert property ($countones(~chipSelect_n) <= 1) else $error("bad");
  a_data_hold: assert property (!idle |-> $stable(dataInputs)) else $error("bad");
  a_cs_stretch: assert property ($fell(idle) |=> !idle ##1 idle) else $error("bad");
  a_ack_follows: assert property ($rose(idle) |-> !transferAcknowledge_n) else $error("bad");
  a_ack_done: assert property (!transferAcknowledge_n |=> writeDone) else $error("bad");
  a_done_time: assert property (take |-> ##5 writeDone) else $error("bad");
  a_msb_flip: assert property (take |=> dataInputs ==
    ($past(writeSample) ^ {$past(twosComplement), {(WIDTH-1){1'b0}}})) else $error("bad");
  a_last_code: assert property (writeDone |-> lastCode == dataInputs) else $error("bad");
  c_twos: cover property (take && twosComplement);
  c_top: cover property (!chipSelect_n[NPORTS-1]);
  c_refused: cover property (writeReq && !writeReady);
endmodule // dac_write_host_sva
bind dac_write_host dac_write_host_sva #(.WIDTH(WIDTH), .NPORTS(NPORTS)) chk (.*);

// file: testbench/dac_device_model.sv
// Converter input latches, one per select
`timescale 1ns/100ps
module dac_device_model (input wire [7:0] chipSelect_n, input wire [11:0] dataInputs,
  output logic [95:0] held = 0);
  logic [7:0] prev = 8'hFF;
  always @(chipSelect_n) begin
    for (int i = 0; i < 8; i++) if (chipSelect_n[i] && !prev[i]) held[i*12+:12] = dataInputs;
    prev = chipSelect_n;
  end
endmodule // dac_device_model

// file: testbench/dac_write_host_test.sv
// Bench for the DAC write host
`timescale 1ns/100ps
module dac_write_host_test;
  logic clk = 0, rst_n = 0, writeReq = 0, twosComplement = 0;
  logic [11:0] writeSample = 12'h000;
  logic [2:0] writePort = 3'h0;
  wire writeReady, writeDone, transferAcknowledge_n;
  wire [11:0] dataInputs, lastCode;
  wire [7:0] chipSelect_n;
  wire [95:0] held;
  int bad_count = 0, checks_done = 0, cycles = 0, n, expCode[8];
  dac_write_host dut (.*);
  dac_device_model dev (.*);
  initial forever #25 clk = ~clk;
  always @(posedge clk) if (++cycles == 2000) begin bad_count++; test_done(); end
  task automatic chk(input logic ok);
    checks_done++;
    if (ok !== 1'b1) begin bad_count++; $display("wrong value at %0t: step %0d", $time, n); end
  endtask
  task automatic wr(input logic [11:0] s, input logic [2:0] p, input logic t);
    n = 0;
    while (writeReady !== 1'b1 && n < 20) begin @(posedge clk); #1; n++; end
    writeReq = 1; writeSample = s; writePort = p; twosComplement = t;
    expCode[p] = t ? {~s[11], s[10:0]} : s;
    n = 0;
    // Busy-time request with other data must be ignored
    do begin @(posedge clk); #1; n++; if (n <= 3) begin writeReq = (n == 2); writeSample = (n == 2) ? ~s : s; end end
    while (writeDone !== 1'b1 && n < 9);
    chk(n == 5);
    chk(lastCode === 12'(expCode[p]));
    for (int i = 0; i < 8; i++) chk(held[i*12+:12] === 12'(expCode[i]));
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    void'($urandom(62459));
    repeat (10) @(posedge clk);
    #1 rst_n = 1;
    for (int c = 0; c < 48; c++) wr(c % 3 == 0 ? 12'h000 : c % 3 == 1 ? 12'hFFF : 12'h800, 3'(c), c >= 24);
    $display("test corner codes done");
    // Mid-run reset: host outputs go idle, the device keeps its codes
    rst_n = 0;
    repeat (2) @(posedge clk);
    #1 chk(writeReady === 1'b0 && writeDone === 1'b0 && chipSelect_n === 8'hFF && transferAcknowledge_n === 1'b1 && lastCode === 12'h000);
    for (int i = 0; i < 8; i++) chk(held[i*12+:12] === 12'(expCode[i]));
    rst_n = 1;
    $display("test mid-run reset done");
    repeat (40) wr(12'($urandom), 3'($urandom), 1'($urandom));
    $display("test random writes done");
    test_done();
  end
endmodule // dac_write_host_test
